// ===== shared/ec_crc4_lpbk_consts.vh
// Constants for the primary-rate CRC-4 inhibit and loopback control block
`ifndef EC_CRC4_LPBK_CONSTS_VH
`define EC_CRC4_LPBK_CONSTS_VH

// Bit positions inside a 256-bit frame: bits 1 to 3 of timeslot zero, and the last bit
`define EC_POS_BIT1    8'h00
`define EC_POS_BIT2    8'h01
`define EC_POS_BIT3    8'h02
`define EC_POS_LAST    8'hff
// Timeslots carrying alignment (0) and signalling (16), not B-channels
`define EC_TS_ZERO     5'h00
`define EC_TS_SIG      5'h10
// Multiframe alignment word seen in bit 1 of frames 1,3,5,7,9,11
`define EC_MFAS_WORD   6'h0b
`define EC_MF_FRAME11  4'hb
`define EC_MF_FRAME0   4'h0
`define EC_SMF_MASK    3'h0
`define EC_CRC_ZERO    4'h0
`define EC_SMF_FULL    2'h2
`define EC_SMF_ONE     2'h1
`define EC_SMF_NONE    2'h0
// Frame count just before a sub-multiframe boundary
`define EC_SMF_LAST    3'h7

`endif

// ===== src/ec_crc4_lpbk_ctrl.v
// CRC-4 inhibit, CRC-4 multiframe check and loopback control for a primary-rate line
`timescale 1ns/1ps
`default_nettype none
`include "ec_crc4_lpbk_consts.vh"

module ec_crc4_lpbk_ctrl (
  input  wire        i_core_clk,
  input  wire        i_rst_n,
  input  wire        i_crc_inhibit,
  input  wire        i_internal_test,
  input  wire [29:0] i_loop_b_chan,
  input  wire        i_bit_valid,
  input  wire        i_frame_start,
  input  wire        i_rx_bit,
  input  wire        i_tx_bit,
  output reg         o_tx_bit,
  output reg         o_tx_valid,
  output reg         o_local_crc_error_report,
  output reg         o_crc_mf_locked,
  output reg         o_remote_alarm_indication
);

  ////////////////////////////////////////////////////////////////////////////
  // Multiframe search states, one-hot
  localparam [2:0] ST_OFF    = 3'b001;
  localparam [2:0] ST_SEARCH = 3'b010;
  localparam [2:0] ST_LOCK   = 3'b100;

  // CRC-4 step, generator x^4 + x + 1, first bit of the block enters first
  function [3:0] crc4_step;
    input [3:0] crc;
    input       din;
    reg         fb;
    begin
      fb        = crc[3] ^ din;
      crc4_step = {crc[2], crc[1], crc[0] ^ fb, fb};
    end
  endfunction

  // Loopback select for a timeslot; timeslots 0 and 16 are never B-channels
  function chan_looped;
    input [4:0]  ts;
    input [29:0] mask;
    begin
      if (ts == `EC_TS_ZERO || ts == `EC_TS_SIG) begin
        chan_looped = 1'b0;
      end else if (ts < `EC_TS_SIG) begin
        chan_looped = mask[ts - 5'h01];
      end else begin
        chan_looped = mask[ts - 5'h02];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  reg [2:0] state_reg,   state_next;
  reg [7:0] pos_reg,     pos_next;
  reg [3:0] frame_reg,   frame_next;
  reg       bit1_reg,    bit1_next;
  reg       nfas_reg,    nfas_next;
  reg [5:0] mfas_sh_reg, mfas_sh_next;
  reg [3:0] crc_reg,     crc_next;
  reg [3:0] crc_prev_reg, crc_prev_next;
  reg [3:0] rx_c_reg,    rx_c_next;
  reg [1:0] smf_seen_reg, smf_seen_next;
  reg       err_next;
  reg       rai_next;
  reg       tx_next;

  wire [7:0] pos      = i_frame_start ? `EC_POS_BIT1 : pos_reg;
  wire [4:0] ts       = pos[7:3];
  wire       fas_fr   = ~frame_reg[0];
  // Taken from the registered count so the head flag never reads the receive process's own result
  wire       smf_head = i_bit_valid && i_frame_start && (frame_reg[2:0] == `EC_SMF_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Receive side: alignment word search, lock keeping and CRC-4 check
  always @* begin
    state_next    = state_reg;
    pos_next      = pos_reg;
    frame_next    = frame_reg;
    bit1_next     = bit1_reg;
    nfas_next     = nfas_reg;
    mfas_sh_next  = mfas_sh_reg;
    crc_next      = crc_reg;
    crc_prev_next = crc_prev_reg;
    rx_c_next     = rx_c_reg;
    smf_seen_next = smf_seen_reg;
    err_next      = 1'b0;
    rai_next      = o_remote_alarm_indication;
    if (i_bit_valid) begin
      pos_next = pos + 8'h01;
      if (i_frame_start) begin
        frame_next = frame_reg + 4'h1;
      end
      if (pos == `EC_POS_BIT1) begin
        bit1_next = i_rx_bit;
      end
      if (pos == `EC_POS_BIT2) begin
        nfas_next = i_rx_bit;
        if (i_rx_bit) begin
          mfas_sh_next = {mfas_sh_reg[4:0], bit1_reg};
        end
      end
      // Alarm bit of frames without the alignment word
      if (pos == `EC_POS_BIT3 && nfas_reg) begin
        rai_next = i_rx_bit;
      end
    end
    case (state_reg)
      ST_OFF: begin
        smf_seen_next = `EC_SMF_NONE;
        if (!i_crc_inhibit) begin
          state_next = ST_SEARCH;
        end
      end
      ST_SEARCH: begin
        smf_seen_next = `EC_SMF_NONE;
        // Six bits seen means we stand in frame 11 of the multiframe
        if (i_bit_valid && pos == `EC_POS_BIT2 && i_rx_bit &&
            {mfas_sh_reg[4:0], bit1_reg} == `EC_MFAS_WORD) begin
          state_next = ST_LOCK;
          frame_next = `EC_MF_FRAME11;
          crc_next   = `EC_CRC_ZERO;
        end
      end
      ST_LOCK: begin
        if (i_bit_valid) begin
          // C bits sit in bit 1 of alignment frames and count as zero in the sum on frames marked by i_frame_start
          if (pos == `EC_POS_BIT1 && fas_fr && !i_frame_start) begin
            rx_c_next = {rx_c_reg[2:0], i_rx_bit};
          end
          if (pos == `EC_POS_BIT1 && i_frame_start && ~frame_next[0]) begin
            rx_c_next = {rx_c_reg[2:0], i_rx_bit};
          end
          if (smf_head) begin
            crc_prev_next = crc_reg;
            crc_next      = crc4_step(`EC_CRC_ZERO, 1'b0);
            if (smf_seen_reg != `EC_SMF_FULL) begin
              smf_seen_next = smf_seen_reg + `EC_SMF_ONE;
            end
            // C bits of the finished block check the block before it
            if (smf_seen_reg == `EC_SMF_FULL && rx_c_reg != crc_prev_reg) begin
              err_next = 1'b1;
            end
          end else if (pos == `EC_POS_BIT1 && ~frame_next[0] && i_frame_start) begin
            crc_next = crc4_step(crc_reg, 1'b0);
          end else begin
            crc_next = crc4_step(crc_reg, i_rx_bit);
          end
          // Loss of the alignment word drops back to search
          if (pos == `EC_POS_BIT2 && i_rx_bit && frame_reg == `EC_MF_FRAME11 &&
              {mfas_sh_reg[4:0], bit1_reg} != `EC_MFAS_WORD) begin
            state_next = ST_SEARCH;
          end
        end
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
    // Inhibit overrides search, lock and CRC check: no search, no lock, no report
    if (i_crc_inhibit) begin
      state_next = ST_OFF;
      err_next   = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit side; test mode sends all ones rather than live frames
  always @* begin
    tx_next = i_tx_bit;
    if (i_internal_test) begin
      tx_next = 1'b1;
    end else if (i_crc_inhibit && pos == `EC_POS_BIT1) begin
      tx_next = 1'b1;
    end else if (chan_looped(ts, i_loop_b_chan)) begin
      // Receive and transmit share bit timing, so the loop needs no frame store
      tx_next = i_rx_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State and output registers
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_reg                 <= ST_OFF;
      pos_reg                   <= `EC_POS_BIT1;
      frame_reg                 <= `EC_MF_FRAME0;
      bit1_reg                  <= 1'b0;
      nfas_reg                  <= 1'b0;
      mfas_sh_reg               <= 6'h00;
      crc_reg                   <= `EC_CRC_ZERO;
      crc_prev_reg              <= `EC_CRC_ZERO;
      rx_c_reg                  <= `EC_CRC_ZERO;
      smf_seen_reg              <= `EC_SMF_NONE;
      o_tx_bit                  <= 1'b1;
      o_tx_valid                <= 1'b0;
      o_local_crc_error_report  <= 1'b0;
      o_crc_mf_locked           <= 1'b0;
      o_remote_alarm_indication <= 1'b0;
    end else begin
      state_reg                 <= state_next;
      pos_reg                   <= pos_next;
      frame_reg                 <= frame_next;
      bit1_reg                  <= bit1_next;
      nfas_reg                  <= nfas_next;
      mfas_sh_reg               <= mfas_sh_next;
      crc_reg                   <= crc_next;
      crc_prev_reg              <= crc_prev_next;
      rx_c_reg                  <= rx_c_next;
      smf_seen_reg              <= smf_seen_next;
      o_tx_bit                  <= i_bit_valid ? tx_next : o_tx_bit;
      o_tx_valid                <= i_bit_valid;
      o_local_crc_error_report  <= err_next;
      o_crc_mf_locked           <= (state_next == ST_LOCK);
      o_remote_alarm_indication <= rai_next;
    end
  end

endmodule // ec_crc4_lpbk_ctrl
`default_nettype wire

// ===== tb/ec_crc4_lpbk_ctrl_assertions.sv
// Checker for the CRC-4 inhibit and loopback control block
`timescale 1ns/1ps
`default_nettype none
module ec_crc4_lpbk_ctrl_chk (
  input wire logic        i_core_clk,
  input wire logic        i_rst_n,
  input wire logic        i_crc_inhibit,
  input wire logic        i_internal_test,
  input wire logic [29:0] i_loop_b_chan,
  input wire logic        i_bit_valid,
  input wire logic        i_frame_start,
  input wire logic        i_rx_bit,
  input wire logic        i_tx_bit,
  input wire logic        o_tx_bit,
  input wire logic        o_tx_valid,
  input wire logic        o_local_crc_error_report,
  input wire logic        o_crc_mf_locked,
  input wire logic        o_remote_alarm_indication
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////
  // Own bit position tracker, so loop checks do not trust the design's counter
  logic [7:0] pos_reg;
  wire  [7:0] pos_next = i_frame_start ? 8'h00 : pos_reg + 8'h01;
  wire  [4:0] ts       = pos_next[7:3];
  wire        loop_en  = ts != 5'h00 && ts != 5'h10
                         && i_loop_b_chan[ts - (ts > 5'h10 ? 5'h02 : 5'h01)];
  always @(posedge i_core_clk)
    if (!i_rst_n)
      pos_reg <= 8'h00;
    else if (i_bit_valid)
      pos_reg <= pos_next;
  ////////////////////////////////////////////////////////////////
  // Two inhibit cycles give the registered flags time to drop
  a_inhibit_no_lock: assert property (i_crc_inhibit ##1 i_crc_inhibit |-> !o_crc_mf_locked)
    else $error("Lock held under inhibit");
  a_inhibit_no_err: assert property (i_crc_inhibit ##1 i_crc_inhibit |-> !o_local_crc_error_report)
    else $error("Error report under inhibit");
  a_inhibit_bit_one: assert property (i_bit_valid && i_frame_start && i_crc_inhibit |=> o_tx_bit)
    else $error("Bit 1 not forced high");
  a_tx_valid_delay: assert property (i_bit_valid |=> o_tx_valid)
    else $error("Line bit valid missing");
  a_loop_return: assert property (i_bit_valid && loop_en && !i_internal_test
    |=> o_tx_bit == $past(i_rx_bit)) else $error("Looped channel wrong");
  a_test_ones: assert property (i_bit_valid && i_internal_test |=> o_tx_bit)
    else $error("Frame sent during test");
  a_pass_tx: assert property (i_bit_valid && !i_internal_test && !loop_en
    && pos_next != 8'h00 |=> o_tx_bit == $past(i_tx_bit)) else $error("User bit not sent");
  a_err_pulse: assert property (o_local_crc_error_report |=> !o_local_crc_error_report)
    else $error("Error report too long");
  c_lock: cover property ($rose(o_crc_mf_locked));
  c_err: cover property (o_local_crc_error_report);
  c_loop: cover property (i_bit_valid && loop_en);
endmodule // ec_crc4_lpbk_ctrl_chk
bind ec_crc4_lpbk_ctrl ec_crc4_lpbk_ctrl_chk u_chk (.*);
`default_nettype wire

// ===== tb/ec_crc4_lpbk_ctrl_tb.sv
// Self-checking bench for the CRC-4 inhibit and loopback control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t got %b want %b", $time, a, b); end end
module ec_crc4_lpbk_ctrl_tb;
  logic        clk = 1'b0, rst_n = 1'b0, inh = 1'b0, tst = 1'b0, txb = 1'b0;
  logic        alarm = 1'b0, bad = 1'b0, seen;
  logic [29:0] loop = 30'h0;
  wire  [7:0]  pos;
  wire         valid, fs, rxb, o_tx, o_val, o_err, o_lock, o_rai;
  integer      err_count = 0, n_checks = 0, i, k;
  // Rows: inhibit, test, loop enables, tx bit, position, expected line bit
  logic [41:0] rows [9] = '{{2'h0, 30'h0, 1'b1, 8'h08, 1'b1}, {2'h0, 30'h0, 1'b0, 8'h08, 1'b0},
    {2'h0, 30'h1, 1'b1, 8'h08, 1'b0}, {2'h0, 30'h2, 1'b1, 8'h08, 1'b1},
    {2'h0, 30'h8000, 1'b1, 8'h88, 1'b0}, {2'h0, 30'h3fffffff, 1'b1, 8'h80, 1'b1},
    {2'h2, 30'h0, 1'b0, 8'h00, 1'b1}, {2'h0, 30'h0, 1'b0, 8'h00, 1'b0},
    {2'h1, 30'h1, 1'b0, 8'h08, 1'b1}};
  always #50 clk = ~clk;
  ec_line_model u_line (.i_core_clk(clk), .i_alarm(alarm), .i_bad_crc(bad), .o_pos(pos),
    .o_bit_valid(valid), .o_frame_start(fs), .o_rx_bit(rxb));
  ec_crc4_lpbk_ctrl dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_crc_inhibit(inh),
    .i_internal_test(tst), .i_loop_b_chan(loop), .i_bit_valid(valid), .i_frame_start(fs),
    .i_rx_bit(rxb), .i_tx_bit(txb), .o_tx_bit(o_tx), .o_tx_valid(o_val),
    .o_local_crc_error_report(o_err), .o_crc_mf_locked(o_lock), .o_remote_alarm_indication(o_rai));
  ////////////////////////////////////////////////////////////////
  task step(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Watchdog sized well past the longest lock and error waits
  initial begin
    #8000000;
    err_count++;
    wrap_up;
  end
  initial begin
    step(3);
    `CHK({o_tx, o_val, o_err, o_lock, o_rai}, 5'h10)
    rst_n = 1'b1;
    for (i = 0; i < 9; i++) begin
      {inh, tst, loop, txb} = rows[i][41:9];
      while (pos !== rows[i][8:1]) step(1);
      step(1);
      `CHK(o_tx, rows[i][0])
    end
    {inh, tst, loop} = 32'h0;
    for (k = 0; k < 10000 && o_lock !== 1'b1; k++) step(1);
    `CHK(o_lock, 1'b1)
    alarm = 1'b1;
    seen  = 1'b0;
    // Clean line: at least two CRC compares must pass with no error and no lock loss
    for (k = 0; k < 7500; k++) begin
      step(1);
      seen = seen | o_err;
    end
    `CHK(o_rai, 1'b1)
    `CHK(seen, 1'b0)
    `CHK(o_lock, 1'b1)
    bad = 1'b1;
    for (k = 0; k < 12000 && o_err !== 1'b1; k++) step(1);
    `CHK(o_err, 1'b1)
    inh = 1'b1;
    step(2);
    `CHK(o_lock, 1'b0)
    seen = 1'b0;
    for (k = 0; k < 10000; k++) begin
      step(1);
      seen = seen | o_err;
    end
    `CHK(seen, 1'b0)
    {inh, bad} = 2'h0;
    for (k = 0; k < 10000 && o_lock !== 1'b1; k++) step(1);
    `CHK(o_lock, 1'b1)
    wrap_up;
  end
endmodule // ec_crc4_lpbk_ctrl_tb
`default_nettype wire

// ===== tb/ec_line_model.sv
// Network-side model: framed line stream with CRC-4 multiframe
`timescale 1ns/1ps
`default_nettype none
module ec_line_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_alarm,
  input  wire logic       i_bad_crc,
  output wire logic [7:0] o_pos,
  output wire logic       o_bit_valid,
  output wire logic       o_frame_start,
  output var  logic       o_rx_bit
);
  localparam logic [7:0] MFAS = 8'hf4;
  localparam logic [7:0] FAS  = 8'hd8;
  logic [11:0] cnt_reg = 12'h000;
  logic [3:0]  crc_reg = 4'h0;
  logic [3:0]  sum_reg = 4'h0;
  wire  [3:0]  f    = cnt_reg[11:8];
  wire         ts0  = cnt_reg[7:3] == 5'h00;
  wire         is_c = ts0 && !f[0] && cnt_reg[2:0] == 3'h0;
  wire         d    = !is_c && o_rx_bit;
  wire  [3:0]  crc_next = {crc_reg[2:0], 1'b0} ^ ({4{crc_reg[3] ^ d}} & 4'h3);
  assign o_pos = cnt_reg[7:0];
  assign o_bit_valid = 1'b1;
  assign o_frame_start = o_pos == 8'h00;
  // Bits back to back; the sum of one sub-multiframe goes into the next
  always @(posedge i_core_clk) begin
    cnt_reg <= cnt_reg + 12'h001;
    crc_reg <= cnt_reg[10:0] == 11'h7ff ? 4'h0 : crc_next;
    if (cnt_reg[10:0] == 11'h7ff)
      sum_reg <= crc_next;
  end
  // Payload idles low; the alarm rides in bit 3 of the frames without the alignment word
  always @* begin
    o_rx_bit = 1'b0;
    if (ts0 && f[0])
      o_rx_bit = cnt_reg[2:0] == 3'h0 ? MFAS[f[3:1]] : (cnt_reg[2:0] != 3'h2 || i_alarm);
    else if (is_c)
      o_rx_bit = sum_reg[~f[2:1]] ^ i_bad_crc;
    else if (ts0)
      o_rx_bit = FAS[cnt_reg[2:0]];
  end
endmodule // ec_line_model
`default_nettype wire
